// ### hdl/afe_cfg_map.vh
// Register offsets, field positions and reset values of the front-end config bank
`ifndef AFE_CFG_MAP_VH
`define AFE_CFG_MAP_VH

// --------------------
// Offsets
// --------------------
`define OFS_PIN8_CFG     8'h28
`define OFS_PIN9_CFG     8'h29
`define OFS_SM_CFG       8'h2a
`define OFS_HP_DAC       8'h2b
`define OFS_LP_DAC_HI    8'h2c
`define OFS_LP_DAC_LO    8'h2d
`define OFS_SCAN_CFG     8'h2e
`define OFS_CONV_MUX     8'h2f
`define OFS_PROT_IRQ_EN  8'h30

// --------------------
// Reset values and writable masks
// --------------------
`define RST_REG          8'h00
`define RD_UNMAPPED      8'h00
`define MASK_LP_DAC_LO   8'h03
`define MASK_PROT_EN     8'h77

// --------------------
// Pin configuration fields
// --------------------
`define F_MODE           7:6
`define F_OPT            5:4
`define F_GAIN           5:3
`define F_POL            3
`define F_MUX            2:0
`define B_OPT1           5
`define B_OPT0           4
`define F_POL9_SPEC      4
`define MODE_IO          2'h0
`define MODE_GAIN        2'h1
`define MODE_CMP         2'h2
`define MODE_SPEC        2'h3
`define OPT_INPUT        2'h0
`define OPT_OPEN_DRAIN   2'h2
`define MUX_OWN          3'h0
`define SPEC_PHASE_A     3'h4
`define SPEC_PHASE_B     3'h5

// --------------------
// Signal manager, scan config and conversion mux fields
// --------------------
`define B_HYST_RANGE     7
`define F_BLANK          6:5
`define B_PIN6_HYST      4
`define B_HP_HYST        3
`define B_LP_HYST        2
`define B_LP_ROUTE       1
`define B_HP_ROUTE       0
`define F_PIN_HOLD_EN    7:5
`define B_SCAN_EN        4
`define B_CONV_BUF       3
`define F_DIFF_HOLD_EN   2:0
`define F_GUARD          7:6
`define GUARD_OK         2'h1
`define B_PIN_ENGAGE     5
`define B_DIFF_ENGAGE    4
`define F_CHAN           3:0
`define F_EXTERNAL_MUX_SERIAL_PORT_BITS      5:0
`define CHAN_HALF_REF    4'hf
`define CHAN_DIFF_LAST   4'h2
`define CHAN_BUS_LAST    4'ha
`define CHAN_BUS_OFS     4'h2

`endif

// ### hdl/analog_front_end_config_regs.v
// Configuration register bank for the analog front end, pins eight and nine
//
// Functional notes
// - IO option: 00 input, 10 open-drain.
// - IO mux: own drive bit or bus line.
// - IO polarity bit: zero high, one low.
// - Gain code: bypass, then 1x to 48x.
// - Gain mux: own analog line or 1-7.
// - Comparator reference: threshold or lines 1-3.
// - Comparator output, polarity, to chosen line.
// - Special input mux: reference, lines, phases.
// - Pin eight options: hold source, routing.
// - Pin nine option picks position comparator.
// - Blanking mode field in bits 6:5.
// - Bits 4,3,2 enable comparator hysteresis.
// - Bits 1,0 route DACs to lines.
// - High DAC code N gives N/256.
// - Low DAC ten-bit code across two registers.
// - Pin holds need enable and engage bit.
// - Hold gain output, or comparator in special.
// - Differential holds need enable and engage.
// - Scan enable gives mux register to port.
// - Channel selector decode of sixteen codes.
// - Protection enables reset to zero.
`timescale 1ns/1ns
`include "afe_cfg_map.vh"

module analog_front_end_config_regs #(
    parameter DW = 8,
    parameter AW = 8
) (
    input  wire          clk,
    input  wire          rstn,
    // Decoded register access from the serial slave
    input  wire          wr_en,
    input  wire          rd_en,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata,
    output reg           rd_valid,
    // External serial mux port, decoded
    input  wire          external_mux_serial_port_wr,
    input  wire [DW-1:0] external_mux_serial_port_data,
    // Pin seven state kept elsewhere
    input  wire [1:0]    pin7_mode,
    input  wire [2:0]    cmp_raw,
    input  wire [2:0]    cmp_held,
    input  wire [1:0]    pin_i,
    input  wire [1:0]    output_drive_bit,
    input  wire [7:1]    digital_bus_line,
    // Per pin, index 0 is pin eight, index 1 pin nine
    output wire [1:0]    pin_o,
    output wire [1:0]    pin_oe,
    output reg  [1:0]    input_status_bit,
    output reg  [1:0]    db_drive_en,
    output reg  [7:0]    db_drive_line,
    output reg  [1:0]    db_drive_val,
    output reg  [1:0]    gain_bypass,
    output reg  [11:0]   amp_gain,
    output reg  [7:0]    ab_route_line,
    output reg  [3:0]    cmp_ref_sel,
    output reg  [5:0]    spec_in_sel,
    output reg  [1:0]    spec_in_reserved,
    output reg           shared_pin_irq,
    output reg           pos_detect,
    // Signal manager
    output wire          hysteresis_range_select,
    output wire          blank_leading,
    output wire          blank_trailing,
    output wire          pin6_hyst_enable,
    output wire          high_prot_hyst_enable,
    output wire          low_prot_hyst_enable,
    output wire          low_dac_route_enable,
    output wire          high_dac_route_enable,
    output wire [7:0]    high_prot_dac,
    output wire [8:0]    high_prot_dac_frac,
    output wire [9:0]    low_prot_dac,
    // Hold circuits and conversion mux
    output wire [2:0]    pin_hold_active,
    output wire [2:0]    pin_hold_cmp_src,
    output wire [2:0]    diff_hold_active,
    output wire          conv_buffer_enable,
    output wire          scan_ctrl_enable,
    output reg           conv_half_ref,
    output reg  [2:0]    conv_diff_sel,
    output reg  [3:0]    conv_bus_line,
    output wire [7:0]    prot_irq_enable
);

// --------------------
// Helpers
// --------------------
// Gain 0 means bypass and reports zero
function [5:0] gain_of;
    input [2:0] code;
    begin
        case (code)
            3'h1:    gain_of = 6'h01;
            3'h2:    gain_of = 6'h02;
            3'h3:    gain_of = 6'h04;
            3'h4:    gain_of = 6'h08;
            3'h5:    gain_of = 6'h10;
            3'h6:    gain_of = 6'h20;
            3'h7:    gain_of = 6'h30;
            default: gain_of = 6'h00;
        endcase
    end
endfunction

// Code zero picks the pin's own line, others the numbered line
function [3:0] line_of;
    input [2:0] code;
    input [3:0] own;
    begin
        if (code == `MUX_OWN)
            line_of = own;
        else
            line_of = {1'b0, code};
    end
endfunction

// --------------------
// Registers
// --------------------
reg [7:0] pin8_cfg_r;
reg [7:0] pin9_cfg_r;
reg [7:0] sm_cfg_r;
reg [7:0] hp_dac_r;
reg [7:0] lp_dac_hi_r;
reg [1:0] lp_dac_lo_r;
reg [7:0] scan_cfg_r;
reg [5:0] conv_mux_r;
reg [7:0] prot_en_r;

wire mux_cpu_ok;
wire mux_wr_cpu;
wire mux_wr_port;

assign mux_cpu_ok  = ~scan_cfg_r[`B_SCAN_EN];
assign mux_wr_cpu  = wr_en && (addr == `OFS_CONV_MUX) && mux_cpu_ok
                     && (wdata[`F_GUARD] == `GUARD_OK);
assign mux_wr_port = external_mux_serial_port_wr && scan_cfg_r[`B_SCAN_EN];

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        pin8_cfg_r  <= `RST_REG;
        pin9_cfg_r  <= `RST_REG;
        sm_cfg_r    <= `RST_REG;
        hp_dac_r    <= `RST_REG;
        lp_dac_hi_r <= `RST_REG;
        lp_dac_lo_r <= 2'h0;
        scan_cfg_r  <= `RST_REG;
        conv_mux_r  <= 6'h00;
        prot_en_r   <= `RST_REG;
    end else begin
        if (wr_en) begin
            case (addr)
                `OFS_PIN8_CFG:    pin8_cfg_r  <= wdata;
                `OFS_PIN9_CFG:    pin9_cfg_r  <= wdata;
                `OFS_SM_CFG:      sm_cfg_r    <= wdata;
                `OFS_HP_DAC:      hp_dac_r    <= wdata;
                `OFS_LP_DAC_HI:   lp_dac_hi_r <= wdata;
                `OFS_LP_DAC_LO:   lp_dac_lo_r <= wdata[1:0];
                `OFS_SCAN_CFG:    scan_cfg_r  <= wdata;
                `OFS_PROT_IRQ_EN: prot_en_r   <= wdata & `MASK_PROT_EN;
                default:          ;
            endcase
        end
        // Port write wins only while it owns the register
        if (mux_wr_port)
            conv_mux_r <= external_mux_serial_port_data[`F_EXTERNAL_MUX_SERIAL_PORT_BITS];
        else if (mux_wr_cpu)
            conv_mux_r <= wdata[`F_EXTERNAL_MUX_SERIAL_PORT_BITS];
    end
end

// --------------------
// Read port
// --------------------
reg [7:0] rd_nxt;

always @* begin
    case (addr)
        `OFS_PIN8_CFG:    rd_nxt = pin8_cfg_r;
        `OFS_PIN9_CFG:    rd_nxt = pin9_cfg_r;
        `OFS_SM_CFG:      rd_nxt = sm_cfg_r;
        `OFS_HP_DAC:      rd_nxt = hp_dac_r;
        `OFS_LP_DAC_HI:   rd_nxt = lp_dac_hi_r;
        `OFS_LP_DAC_LO:   rd_nxt = {6'h00, lp_dac_lo_r};
        `OFS_SCAN_CFG:    rd_nxt = scan_cfg_r;
        // Guard bits read back as the only legal write value
        `OFS_CONV_MUX:    rd_nxt = {`GUARD_OK, conv_mux_r};
        `OFS_PROT_IRQ_EN: rd_nxt = prot_en_r;
        default:          rd_nxt = `RD_UNMAPPED;
    endcase
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        rdata    <= 8'h00;
        rd_valid <= 1'b0;
    end else begin
        rd_valid <= rd_en;
        if (rd_en)
            rdata <= rd_nxt;
    end
end

// --------------------
// Pin decode for pins eight and nine
// --------------------
reg [7:0] cfg;
reg [1:0] mode;
reg [1:0] opt;
reg       pol;
reg [2:0] mx;
reg       cmp_eff;
reg [1:0] od_drive;
reg [2:0] pin_val;
reg       pos_src;
integer   i;

always @* begin
    input_status_bit = 2'h0;
    db_drive_en      = 2'h0;
    db_drive_line    = 8'h00;
    db_drive_val     = 2'h0;
    gain_bypass      = 2'h0;
    amp_gain         = 12'h000;
    ab_route_line    = 8'h00;
    cmp_ref_sel      = 4'h0;
    spec_in_sel      = 6'h00;
    spec_in_reserved = 2'h0;
    od_drive         = 2'h0;
    cfg              = 8'h00;
    mode             = 2'h0;
    opt              = 2'h0;
    pol              = 1'b0;
    mx               = 3'h0;
    cmp_eff          = 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
        cfg     = (i == 0) ? pin8_cfg_r : pin9_cfg_r;
        mode    = cfg[`F_MODE];
        opt     = cfg[`F_OPT];
        mx      = cfg[`F_MUX];
        pol     = cfg[`F_POL];
        // Pin nine moves its special-mode polarity up one bit
        if (i == 1 && mode == `MODE_SPEC)
            pol = cfg[`F_POL9_SPEC];
        cmp_eff = cmp_raw[i+1] ^ pol;
        case (mode)
            `MODE_IO: begin
                if (opt == `OPT_INPUT)
                    input_status_bit[i] = pin_i[i] ^ pol;
                if (opt == `OPT_OPEN_DRAIN) begin
                    if (mx == `MUX_OWN)
                        od_drive[i] = output_drive_bit[i] ^ pol;
                    else
                        od_drive[i] = digital_bus_line[mx] ^ pol;
                end
            end
            `MODE_GAIN: begin
                gain_bypass[i]       = (cfg[`F_GAIN] == 3'h0);
                amp_gain[i*6 +: 6]   = gain_of(cfg[`F_GAIN]);
                ab_route_line[i*4 +: 4] =
                    line_of(mx, (i == 0) ? 4'h8 : 4'h9);
            end
            `MODE_CMP: begin
                cmp_ref_sel[i*2 +: 2]   = opt;
                input_status_bit[i]     = cmp_eff;
                db_drive_en[i]          = 1'b1;
                db_drive_val[i]         = cmp_eff;
                db_drive_line[i*4 +: 4] =
                    line_of(mx, (i == 0) ? 4'h8 : 4'h9);
            end
            default: begin
                input_status_bit[i] = cmp_eff;
                spec_in_sel[i*3 +: 3] = mx;
                spec_in_reserved[i]   = (mx > `SPEC_PHASE_B);
            end
        endcase
    end
end

// Open drain: enable pulls low while the logic level is zero
assign pin_o  = 2'h0;
assign pin_oe = {
    (pin9_cfg_r[`F_MODE] == `MODE_IO) &&
    (pin9_cfg_r[`F_OPT] == `OPT_OPEN_DRAIN) && !od_drive[1],
    (pin8_cfg_r[`F_MODE] == `MODE_IO) &&
    (pin8_cfg_r[`F_OPT] == `OPT_OPEN_DRAIN) && !od_drive[0]};

// --------------------
// Position detect and shared interrupt source
// --------------------
wire spec8;
wire spec9;

assign spec8       = (pin8_cfg_r[`F_MODE] == `MODE_SPEC);
assign spec9       = (pin9_cfg_r[`F_MODE] == `MODE_SPEC);

always @* begin
    // Pin eight may take its held comparator value instead of raw
    pin_val[0] = cmp_raw[0];
    pin_val[1] = (pin8_cfg_r[`B_OPT1] ? cmp_held[1] : cmp_raw[1])
                 ^ pin8_cfg_r[`F_POL];
    pin_val[2] = cmp_raw[2] ^ pin9_cfg_r[`F_POL9_SPEC];
    shared_pin_irq = spec8 && !pin8_cfg_r[`B_OPT0] && pin_val[1];
    case (pin9_cfg_r[`F_OPT])
        2'h1:    pos_src = pin_val[0];
        2'h2:    pos_src = pin_val[1];
        2'h3:    pos_src = pin_val[2];
        default: pos_src = 1'b0;
    endcase
    // Pin eight routed to position overrides pin nine's choice
    if (spec8 && pin8_cfg_r[`B_OPT0])
        pos_detect = pin_val[1];
    else if (spec9)
        pos_detect = pos_src;
    else
        pos_detect = 1'b0;
end

// --------------------
// Signal manager and DAC codes
// --------------------
assign hysteresis_range_select = sm_cfg_r[`B_HYST_RANGE];
assign blank_leading  = sm_cfg_r[`F_BLANK] == 2'h1 ||
                        sm_cfg_r[`F_BLANK] == 2'h3;
assign blank_trailing = sm_cfg_r[`F_BLANK] == 2'h2 ||
                        sm_cfg_r[`F_BLANK] == 2'h3;
assign pin6_hyst_enable      = sm_cfg_r[`B_PIN6_HYST];
assign high_prot_hyst_enable = sm_cfg_r[`B_HP_HYST];
assign low_prot_hyst_enable  = sm_cfg_r[`B_LP_HYST];
assign low_dac_route_enable  = sm_cfg_r[`B_LP_ROUTE];
assign high_dac_route_enable = sm_cfg_r[`B_HP_ROUTE];
assign high_prot_dac         = hp_dac_r;
// Fraction numerator over 256; full scale is never reached
assign high_prot_dac_frac    = {1'b0, hp_dac_r};
assign low_prot_dac          = {lp_dac_hi_r, lp_dac_lo_r};

// --------------------
// Hold circuits
// --------------------
wire all_spec;

assign all_spec = spec8 && spec9 && (pin7_mode == `MODE_SPEC);
// Clearing an engage bit drops every enabled hold of its group (pin or differential) at once
assign pin_hold_active  = scan_cfg_r[`F_PIN_HOLD_EN]
                          & {3{conv_mux_r[`B_PIN_ENGAGE]}};
assign pin_hold_cmp_src = {3{all_spec}}
                          & scan_cfg_r[`F_PIN_HOLD_EN];
assign diff_hold_active = scan_cfg_r[`F_DIFF_HOLD_EN]
                          & {3{conv_mux_r[`B_DIFF_ENGAGE]}};
assign conv_buffer_enable = scan_cfg_r[`B_CONV_BUF];
assign scan_ctrl_enable   = scan_cfg_r[`B_SCAN_EN];
assign prot_irq_enable    = prot_en_r;

// --------------------
// Conversion channel decode
// --------------------
wire [3:0] chan;

assign chan = conv_mux_r[`F_CHAN];

always @* begin
    conv_half_ref = (chan == `CHAN_HALF_REF);
    conv_diff_sel = 3'h0;
    conv_bus_line = 4'h0;
    if (chan <= `CHAN_DIFF_LAST)
        conv_diff_sel = 3'h1 << chan[1:0];
    else if (chan <= `CHAN_BUS_LAST)
        conv_bus_line = chan - `CHAN_BUS_OFS;
end

endmodule // analog_front_end_config_regs

// ### test/afe_cfg_sva.sv
// Assertion checker for the front-end config bank
`timescale 1ns/1ns
`include "afe_cfg_map.vh"
module afe_cfg_sva (
    input wire       clk, rstn, wr_en, external_mux_serial_port_wr, scan_ctrl_enable, conv_half_ref,
    input wire       blank_leading, blank_trailing, pin6_hyst_enable,
    input wire       high_prot_hyst_enable, low_prot_hyst_enable,
    input wire       low_dac_route_enable, high_dac_route_enable,
    input wire [7:0] addr, wdata, external_mux_serial_port_data, high_prot_dac, prot_irq_enable,
    input wire [1:0] pin_o,
    input wire [2:0] conv_diff_sel, pin_hold_active, diff_hold_active,
    input wire [3:0] conv_bus_line,
    input wire [8:0] high_prot_dac_frac,
    input wire [9:0] low_prot_dac
);
    // --------------------
    // Helpers
    // --------------------
    wire [7:0] conv_out = {conv_half_ref, conv_diff_sel, conv_bus_line};
    wire       mux_hit  = wr_en && addr == `OFS_CONV_MUX;

    function automatic [7:0] chan(input [3:0] c);
        chan = {c == 4'hf, (c < 4'h3) ? 3'h1 << c : 3'h0,
                (c > 4'h2 && c < 4'hb) ? c - 4'h2 : 4'h0};
    endfunction

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_cpu_mux;
        mux_hit && wdata[7:6] == `GUARD_OK && !scan_ctrl_enable && !external_mux_serial_port_wr;
    endsequence
    sequence s_cpu_refused;
        mux_hit && !external_mux_serial_port_wr && (scan_ctrl_enable || wdata[7:6] != `GUARD_OK);
    endsequence
    sequence s_port_mux;
        external_mux_serial_port_wr && scan_ctrl_enable;
    endsequence

    // --------------------
    // Properties
    // --------------------
    property p_mux_cpu;
        s_cpu_mux |=> conv_out == chan($past(wdata[3:0]));
    endproperty
    a_mux_cpu: assert property (p_mux_cpu)
        else $error("channel decode wrong after host write");
    property p_mux_refused;
        s_cpu_refused |=> $stable(conv_out);
    endproperty
    a_mux_refused: assert property (p_mux_refused)
        else $error("refused host write changed the channel");
    property p_port_mux;
        s_port_mux |=> conv_out == chan($past(external_mux_serial_port_data[3:0]));
    endproperty
    a_port_mux: assert property (p_port_mux)
        else $error("port write not taken");
    property p_port_refused;
        external_mux_serial_port_wr && !scan_ctrl_enable && !mux_hit |=> $stable(conv_out);
    endproperty
    a_port_refused: assert property (p_port_refused)
        else $error("port write taken while scan off");
    property p_sm_bits;
        wr_en && addr == `OFS_SM_CFG |=> {blank_trailing, blank_leading,
            pin6_hyst_enable, high_prot_hyst_enable, low_prot_hyst_enable,
            low_dac_route_enable, high_dac_route_enable} == $past(wdata[6:0]);
    endproperty
    a_sm_bits: assert property (p_sm_bits)
        else $error("signal manager outputs wrong");
    property p_hp_dac;
        wr_en && addr == `OFS_HP_DAC |=> high_prot_dac == $past(wdata)
            ##0 high_prot_dac_frac == {1'h0, high_prot_dac};
    endproperty
    a_hp_dac: assert property (p_hp_dac)
        else $error("high dac level wrong");
    property p_lp_dac;
        wr_en && addr == `OFS_LP_DAC_HI |=> low_prot_dac[9:2] == $past(wdata);
    endproperty
    a_lp_dac: assert property (p_lp_dac)
        else $error("low dac upper bits wrong");
    property p_holds;
        wr_en && addr == `OFS_SCAN_CFG |=> scan_ctrl_enable == $past(wdata[4])
            && (pin_hold_active & ~$past(wdata[7:5])) == 3'h0
            && (diff_hold_active & ~$past(wdata[2:0])) == 3'h0;
    endproperty
    a_holds: assert property (p_holds)
        else $error("hold active without enable");
    property p_prot_rst;
        $rose(rstn) |-> prot_irq_enable == 8'h00;
    endproperty
    a_prot_rst: assert property (p_prot_rst)
        else $error("protection enables not zero after reset");
    property p_pin_o;
        pin_o == 2'h0;
    endproperty
    a_pin_o: assert property (p_pin_o)
        else $error("open-drain pin driven high");
endmodule // afe_cfg_sva

bind analog_front_end_config_regs afe_cfg_sva u_sva (.*);

// ### test/host_model.sv
// Host controller and external mux port driving the config bank
`timescale 1ns/1ns
`include "afe_cfg_map.vh"
module host_model (
    input  wire       clk,
    input  wire       rd_valid,
    input  wire [7:0] rdata,
    output reg        wr_en,
    output reg        rd_en,
    output reg        external_mux_serial_port_wr,
    output reg  [7:0] addr,
    output reg  [7:0] wdata,
    output reg  [7:0] external_mux_serial_port_data
);
    initial begin
        wr_en     = 1'h0;
        rd_en     = 1'h0;
        external_mux_serial_port_wr   = 1'h0;
        addr      = 8'h00;
        wdata     = 8'hff;
        external_mux_serial_port_data = 8'hff;
    end

    // Idle lines show the inverse
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            wr_en = 1'h1;
            addr  = a;
            wdata = d;
            @(negedge clk);
            wr_en = 1'h0;
            addr  = ~a;
            wdata = ~d;
        end
    endtask

    task mux_wr(input [5:0] v);
        wr(`OFS_CONV_MUX, {`GUARD_OK, v});
    endtask

    task port_wr(input [7:0] d);
        begin
            @(negedge clk);
            external_mux_serial_port_wr   = 1'h1;
            external_mux_serial_port_data = d;
            @(negedge clk);
            external_mux_serial_port_wr   = 1'h0;
            external_mux_serial_port_data = ~d;
        end
    endtask

    task rd(input [7:0] a, output [7:0] d, output v);
        begin
            @(negedge clk);
            rd_en = 1'h1;
            addr  = a;
            @(negedge clk);
            rd_en = 1'h0;
            addr  = ~a;
            d     = rdata;
            v     = rd_valid;
        end
    endtask
endmodule // host_model

// ### test/tb_top.sv
// Self-checking bench for the front-end config bank
`timescale 1ns/1ns
`include "afe_cfg_map.vh"
module tb_top;
    reg         clk, rstn, rd_v;
    reg  [1:0]  pin7_mode, pin_i, output_drive_bit;
    reg  [2:0]  cmp_raw, cmp_held;
    reg  [7:1]  digital_bus_line;
    reg  [7:0]  rd_d;
    wire        wr_en, rd_en, rd_valid, external_mux_serial_port_wr, shared_pin_irq, pos_detect;
    wire        scan_ctrl_enable, conv_half_ref;
    wire [7:0]  addr, wdata, rdata, external_mux_serial_port_data, db_drive_line, ab_route_line;
    wire [7:0]  prot_irq_enable;
    wire [1:0]  pin_oe, input_status_bit, db_drive_en, db_drive_val, gain_bypass;
    wire [1:0]  spec_in_reserved;
    wire [11:0] amp_gain;
    wire [3:0]  cmp_ref_sel, conv_bus_line;
    wire [5:0]  spec_in_sel;
    wire [9:0]  low_prot_dac;
    wire [2:0]  pin_hold_active, pin_hold_cmp_src, diff_hold_active, conv_diff_sel;
    integer     error_cnt, total_checks, k;
    integer     cycles = 0;

    analog_front_end_config_regs u_dut (
        .clk, .rstn, .wr_en, .rd_en, .addr, .wdata, .rdata, .rd_valid, .external_mux_serial_port_wr,
        .external_mux_serial_port_data, .pin7_mode, .cmp_raw, .cmp_held, .pin_i, .output_drive_bit,
        .digital_bus_line, .pin_o(), .pin_oe, .input_status_bit, .db_drive_en,
        .db_drive_line, .db_drive_val, .gain_bypass, .amp_gain, .ab_route_line,
        .cmp_ref_sel, .spec_in_sel, .spec_in_reserved, .shared_pin_irq, .pos_detect,
        .hysteresis_range_select(), .blank_leading(), .blank_trailing(),
        .pin6_hyst_enable(), .high_prot_hyst_enable(), .low_prot_hyst_enable(),
        .low_dac_route_enable(), .high_dac_route_enable(), .high_prot_dac(),
        .high_prot_dac_frac(), .low_prot_dac, .pin_hold_active, .pin_hold_cmp_src,
        .diff_hold_active, .conv_buffer_enable(), .scan_ctrl_enable, .conv_half_ref,
        .conv_diff_sel, .conv_bus_line, .prot_irq_enable
    );
    host_model u_host (
        .clk, .rd_valid, .rdata, .wr_en, .rd_en, .external_mux_serial_port_wr, .addr, .wdata, .external_mux_serial_port_data
    );

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            error_cnt = error_cnt + 1;
            wrap_up;
        end
    end

    // --------------------
    // Shared tasks
    // --------------------
    task chk(input [15:0] seen, input [15:0] exp, input string what);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task rdc(input [7:0] a, input [7:0] e);
        begin
            u_host.rd(a, rd_d, rd_v);
            chk(rd_v, 1'h1, "rd_valid");
            chk(rd_d, e, "rdata");
        end
    endtask

    function [7:0] dec(input [3:0] c);
        dec = {c == 4'hf, (c < 4'h3) ? 3'h1 << c : 3'h0,
               (c > 4'h2 && c < 4'hb) ? c - 4'h2 : 4'h0};
    endfunction

    task wrap_up;
        begin
            $display("checks %0d errors %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // --------------------
    // Scenarios
    // --------------------
    task t_regs;
        begin
            for (k = 8'h28; k < 8'h32; k = k + 1)
                rdc(k[7:0], (k == `OFS_CONV_MUX) ? 8'h40 : `RST_REG);
            u_host.wr(`OFS_LP_DAC_LO, 8'hff);
            u_host.wr(`OFS_PROT_IRQ_EN, 8'hff);
            u_host.wr(`OFS_LP_DAC_HI, 8'h5a);
            u_host.wr(`OFS_SM_CFG, 8'h6a);
            u_host.wr(`OFS_HP_DAC, 8'hff);
            u_host.wr(8'h31, 8'hff);
            rdc(`OFS_LP_DAC_LO, `MASK_LP_DAC_LO);
            rdc(`OFS_PROT_IRQ_EN, `MASK_PROT_EN);
            rdc(`OFS_SM_CFG, 8'h6a);
            rdc(8'h31, `RD_UNMAPPED);
            chk(low_prot_dac, 10'h16b, "low_prot_dac");
        end
    endtask

    task t_io;
        begin
            u_host.wr(`OFS_PIN8_CFG, 8'h08);
            pin_i = 2'h1;
            #5 chk(input_status_bit[0], 1'h0, "status low pol");
            u_host.wr(`OFS_PIN8_CFG, 8'h00);
            chk(input_status_bit[0], 1'h1, "status");
            output_drive_bit = 2'h1;
            digital_bus_line = 7'h55;
            for (k = 0; k < 8; k = k + 1) begin
                u_host.wr(`OFS_PIN8_CFG, 8'h28 | k[7:0]);
                chk(pin_oe[0], (k == 0) ? 1'h1 : digital_bus_line[k], "pin_oe");
            end
            u_host.wr(`OFS_PIN8_CFG, 8'h20);
            chk(pin_oe[0], 1'h0, "pin_oe high pol");
        end
    endtask

    task t_gain;
        for (k = 0; k < 8; k = k + 1) begin
            u_host.wr(`OFS_PIN8_CFG, 8'h40 | (k[7:0] << 3) | k[7:0]);
            chk(gain_bypass[0], k == 0, "gain_bypass");
            chk(amp_gain[5:0], (k == 7) ? 16'h30 : (k == 0) ? 16'h0 : 16'h1 << (k - 1),
                "amp_gain");
            chk(ab_route_line[3:0], (k == 0) ? 4'h8 : k[3:0], "ab_route_line");
        end
    endtask

    task t_cmp;
        begin
            cmp_raw = 3'h2;
            for (k = 0; k < 8; k = k + 1) begin
                u_host.wr(`OFS_PIN8_CFG, 8'h80 | (k[7:0] << 3) | k[7:0]);
                chk(cmp_ref_sel[1:0], k[2:1], "cmp_ref_sel");
                chk(input_status_bit[0], !k[0], "cmp status");
                chk({db_drive_en[0], db_drive_val[0]}, {1'h1, ~k[0]}, "db_drive");
                chk(db_drive_line[3:0], (k == 0) ? 4'h8 : k[3:0], "db_line");
            end
        end
    endtask

    task t_spec;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                u_host.wr(`OFS_PIN8_CFG, 8'hc0 | k[7:0]);
                chk({spec_in_reserved[0], spec_in_sel[2:0]}, {k > 5, k[2:0]}, "spec");
            end
            u_host.wr(`OFS_PIN8_CFG, 8'hc0);
            chk(shared_pin_irq, 1'h1, "irq raw");
            u_host.wr(`OFS_PIN8_CFG, 8'he0);
            chk(shared_pin_irq, 1'h0, "irq held");
            u_host.wr(`OFS_PIN8_CFG, 8'hd0);
            chk(pos_detect, 1'h1, "pos from pin8");
            u_host.wr(`OFS_PIN8_CFG, 8'hc0);
            u_host.wr(`OFS_PIN9_CFG, 8'he0);
            chk(pos_detect, 1'h1, "pos pin9 select");
            u_host.wr(`OFS_PIN9_CFG, 8'hc0);
            chk(pos_detect, 1'h0, "pos none");
        end
    endtask

    task t_mux;
        begin
            for (k = 0; k < 16; k = k + 1) begin
                u_host.mux_wr(k[5:0]);
                chk({conv_half_ref, conv_diff_sel, conv_bus_line}, dec(k[3:0]), "conv");
            end
            u_host.wr(`OFS_CONV_MUX, 8'h83);
            u_host.wr(`OFS_CONV_MUX, 8'h03);
            rdc(`OFS_CONV_MUX, 8'h4f);
            u_host.port_wr(8'h05);
            rdc(`OFS_CONV_MUX, 8'h4f);
            u_host.wr(`OFS_SCAN_CFG, 8'h10);
            u_host.mux_wr(6'h03);
            rdc(`OFS_CONV_MUX, 8'h4f);
            u_host.port_wr(8'h05);
            rdc(`OFS_CONV_MUX, 8'h45);
            chk(conv_bus_line, 4'h3, "conv port");
            u_host.wr(`OFS_SCAN_CFG, 8'h00);
        end
    endtask

    task t_hold;
        begin
            u_host.wr(`OFS_SCAN_CFG, 8'he7);
            chk({pin_hold_active, diff_hold_active}, 6'h00, "hold idle");
            u_host.mux_wr(6'h30);
            chk({pin_hold_active, diff_hold_active}, 6'h3f, "hold engaged");
            u_host.mux_wr(6'h20);
            chk({pin_hold_active, diff_hold_active}, 6'h38, "diff off");
            pin7_mode = 2'h3;
            u_host.wr(`OFS_PIN9_CFG, 8'hc0);
            chk(pin_hold_cmp_src, 3'h7, "cmp src");
            pin7_mode = 2'h1;
            #5 chk(pin_hold_cmp_src, 3'h0, "gain src");
            u_host.wr(`OFS_SCAN_CFG, 8'h00);
            chk(pin_hold_active, 3'h0, "hold bypass");
        end
    endtask

    initial begin
        rstn = 1'h0;
        pin7_mode = 2'h0;
        pin_i = 2'h0;
        output_drive_bit = 2'h0;
        cmp_raw = 3'h0;
        cmp_held = 3'h0;
        digital_bus_line = 7'h00;
        error_cnt = 0;
        total_checks = 0;
        repeat (8) @(negedge clk);
        rstn = 1'h1;
        t_regs;
        t_io;
        t_gain;
        t_cmp;
        t_spec;
        t_mux;
        t_hold;
        wrap_up;
    end
endmodule // tb_top
